// >>> rtl/esbsr_map.svh
`ifndef ESBSR_MAP_SVH
`define ESBSR_MAP_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define ESBSR_ADDR_W        5
`define ESBSR_STATUS_OFS    5'h00
`define ESBSR_ERROR_OFS     5'h04

// ----------------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------------
`define ESBSR_ST_PFREE      0
`define ESBSR_ST_NPFREE     1
`define ESBSR_ST_VWFREE     2
`define ESBSR_ST_OOBFREE    3
`define ESBSR_ST_PAVAIL     4
`define ESBSR_ST_NPAVAIL    5
`define ESBSR_ST_VWAVAIL    6
`define ESBSR_ST_OOBAVAIL   7
`define ESBSR_ST_FCFREE     8
`define ESBSR_ST_FNPFREE    9
`define ESBSR_ST_FCAVAIL    12
`define ESBSR_ST_FNPAVAIL   13

// ----------------------------------------------------------------------
// error fields and reset values
// ----------------------------------------------------------------------
`define ESBSR_ERR_BITS      8
`define ESBSR_ERR_PUT_NFREE 4
`define ESBSR_ERR_RST       8'h00
`define ESBSR_RDATA_RST     32'h0000_0000
`define ESBSR_LANES_DEF     4
`define ESBSR_VW_DEPTH_DEF  8
`define ESBSR_VW_INDEX_DEF  8'h00

`endif

// >>> rtl/esbsr_pkg.sv
package esbsr_pkg;

    // one virtual wire fifo entry: group index and wire levels
    typedef struct packed {
        logic [7:0] index;
        logic [7:0] data;
    } esbsr_vw_entry_t;

    // channel fifo handshakes from the link engine
    typedef struct packed {
        logic posted_put;
        logic posted_drain;
        logic nonposted_put;
        logic nonposted_drain;
        logic vw_get;
    } esbsr_fifo_ev_t;

endpackage : esbsr_pkg

// >>> rtl/esbsr_status_regs.sv
// Operation
// - status at 0x0, w1c error at 0x4
// - status bit 0: posted fifo empty
// - status bit 1: nonposted fifo empty
// - fixed free bits one, fixed available bits zero
// - status bit 4: posted packet waiting
// - wire change queued; bit 6 while queued
// - link reset keeps fifo contents
// - data bus two or four lanes
// - error bits 0-7 latch, write one clears
`timescale 1ns/10ps
`include "esbsr_map.svh"

module esbsr_status_regs
    import esbsr_pkg::*;
#(
    parameter int         LANES    = `ESBSR_LANES_DEF,
    parameter int         VW_DEPTH = `ESBSR_VW_DEPTH_DEF,
    parameter logic [7:0] VW_INDEX = `ESBSR_VW_INDEX_DEF
) (
    input  wire logic                      clk,
    input  wire logic                      arst_n,
    input  wire logic                      reg_write,
    input  wire logic                      reg_read,
    input  wire logic [`ESBSR_ADDR_W-1:0]  reg_address,
    input  wire logic [31:0]               reg_writedata,
    output logic      [31:0]               reg_readdata,
    input  wire logic                      espi_clk,
    input  wire logic                      espi_reset_n,
    input  wire logic                      espi_cs_n,
    input  wire logic [LANES-1:0]          espi_data_in,
    output logic      [LANES-1:0]          espi_data_out,
    output logic      [LANES-1:0]          espi_data_oe,
    output logic                           espi_alert_n,
    input  wire esbsr_fifo_ev_t            fifo_ev,
    input  wire logic [7:0]                vw_wires,
    output esbsr_vw_entry_t                vw_head,
    input  wire logic [`ESBSR_ERR_BITS-1:0] err_event
);

    localparam int PW = (VW_DEPTH > 1) ? $clog2(VW_DEPTH) : 1;
    localparam int CW = $clog2(VW_DEPTH + 1);

    // ------------------------------------------------------------------
    // status word assembly
    // ------------------------------------------------------------------
    function automatic logic [31:0] build_status(
        input logic pfree,
        input logic npfree,
        input logic pavail,
        input logic vwavail
    );
        logic [31:0] s;
        s = 32'h0000_0000;
        s[`ESBSR_ST_PFREE]    = pfree;
        s[`ESBSR_ST_NPFREE]   = npfree;
        s[`ESBSR_ST_PAVAIL]   = pavail;
        s[`ESBSR_ST_VWAVAIL]  = vwavail;
        s[`ESBSR_ST_VWFREE]   = 1'b1;
        s[`ESBSR_ST_OOBFREE]  = 1'b1;
        s[`ESBSR_ST_FCFREE]   = 1'b1;
        s[`ESBSR_ST_FNPFREE]  = 1'b1;
        s[`ESBSR_ST_NPAVAIL]  = 1'b0;
        s[`ESBSR_ST_OOBAVAIL] = 1'b0;
        s[`ESBSR_ST_FCAVAIL]  = 1'b0;
        s[`ESBSR_ST_FNPAVAIL] = 1'b0;
        return s;
    endfunction : build_status

    // ------------------------------------------------------------------
    // link pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] cs_sync_reg,  cs_sync_next;
    logic [2:0] lrst_sync_reg, lrst_sync_next;
    logic [2:0] lclk_sync_reg, lclk_sync_next;
    logic       cs_n_reg,     cs_n_next;
    logic       lrst_n_reg,   lrst_n_next;

    always_comb begin
        cs_sync_next   = {cs_sync_reg[1:0], espi_cs_n};
        lrst_sync_next = {lrst_sync_reg[1:0], espi_reset_n};
        lclk_sync_next = {lclk_sync_reg[1:0], espi_clk};
        cs_n_next      = cs_n_reg;
        lrst_n_next    = lrst_n_reg;
        if (cs_sync_reg[1] == cs_sync_reg[2]) begin
            cs_n_next = cs_sync_reg[2];
        end
        if (lrst_sync_reg[1] == lrst_sync_reg[2]) begin
            lrst_n_next = lrst_sync_reg[2];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_sync_reg   <= 3'h7;
            lrst_sync_reg <= 3'h0;
            lclk_sync_reg <= 3'h0;
            cs_n_reg      <= 1'b1;
            lrst_n_reg    <= 1'b0;
        end else begin
            cs_sync_reg   <= cs_sync_next;
            lrst_sync_reg <= lrst_sync_next;
            lclk_sync_reg <= lclk_sync_next;
            cs_n_reg      <= cs_n_next;
            lrst_n_reg    <= lrst_n_next;
        end
    end

    // ------------------------------------------------------------------
    // channel 0 packet fifos and channel 1 virtual wire fifo
    // ------------------------------------------------------------------
    esbsr_vw_entry_t vw_mem [VW_DEPTH];
    logic [PW-1:0]   vw_wp_reg,   vw_wp_next;
    logic [PW-1:0]   vw_rp_reg,   vw_rp_next;
    logic [CW-1:0]   vw_cnt_reg,  vw_cnt_next;
    logic [7:0]      vw_last_reg, vw_last_next;
    logic            pc_occ_reg,  pc_occ_next;
    logic            np_occ_reg,  np_occ_next;
    logic            vw_push;
    logic            vw_pop;
    logic            vw_full;
    logic            put_nfree;

    always_comb begin
        vw_full   = (vw_cnt_reg == CW'(VW_DEPTH));
        vw_push   = (vw_wires != vw_last_reg) && !vw_full;
        vw_pop    = fifo_ev.vw_get && (vw_cnt_reg != '0);
        put_nfree = (fifo_ev.posted_put && pc_occ_reg)
                  || (fifo_ev.nonposted_put && np_occ_reg);
        // posted occupancy, put wins over drain
        pc_occ_next = (pc_occ_reg && !fifo_ev.posted_drain)
                    || fifo_ev.posted_put;
        np_occ_next = (np_occ_reg && !fifo_ev.nonposted_drain)
                    || fifo_ev.nonposted_put;
        vw_last_next = vw_push ? vw_wires : vw_last_reg;
        vw_wp_next   = vw_wp_reg;
        vw_rp_next   = vw_rp_reg;
        if (vw_push) begin
            vw_wp_next = (vw_wp_reg == PW'(VW_DEPTH - 1)) ? '0
                       : PW'(vw_wp_reg + 1'b1);
        end
        if (vw_pop) begin
            vw_rp_next = (vw_rp_reg == PW'(VW_DEPTH - 1)) ? '0
                       : PW'(vw_rp_reg + 1'b1);
        end
        vw_cnt_next = CW'(vw_cnt_reg + CW'(vw_push) - CW'(vw_pop));
    end

    // only the bridge reset empties the fifos
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vw_wp_reg   <= '0;
            vw_rp_reg   <= '0;
            vw_cnt_reg  <= '0;
            vw_last_reg <= 8'h00;
            pc_occ_reg  <= 1'b0;
            np_occ_reg  <= 1'b0;
        end else begin
            vw_wp_reg   <= vw_wp_next;
            vw_rp_reg   <= vw_rp_next;
            vw_cnt_reg  <= vw_cnt_next;
            vw_last_reg <= vw_last_next;
            pc_occ_reg  <= pc_occ_next;
            np_occ_reg  <= np_occ_next;
        end
    end

    always_ff @(posedge clk) begin
        if (vw_push) begin
            vw_mem[vw_wp_reg] <= '{index: VW_INDEX, data: vw_wires};
        end
    end

    // ------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------
    logic [`ESBSR_ERR_BITS-1:0] err_reg, err_next;
    logic [31:0]                rdata_next;
    logic [31:0]                status_word;
    logic                       alert_n_next;
    esbsr_vw_entry_t            head_next;

    always_comb begin
        status_word = build_status(!pc_occ_reg, !np_occ_reg, pc_occ_reg,
                                   vw_cnt_reg != '0);
        // latch, set wins over write-one clear
        err_next = err_reg;
        if (reg_write && reg_address == `ESBSR_ERROR_OFS) begin
            err_next = err_reg & ~reg_writedata[`ESBSR_ERR_BITS-1:0];
        end
        err_next = err_next | err_event;
        err_next[`ESBSR_ERR_PUT_NFREE] = err_next[`ESBSR_ERR_PUT_NFREE]
                                       | put_nfree;
        rdata_next = reg_readdata;
        if (reg_read) begin
            case (reg_address)
                `ESBSR_STATUS_OFS: rdata_next = status_word;
                `ESBSR_ERROR_OFS:  rdata_next = {24'h00_0000, err_reg};
                default:           rdata_next = 32'h0000_0000;
            endcase
        end
        alert_n_next = !(lrst_n_reg && cs_n_reg
                         && (pc_occ_reg || vw_cnt_reg != '0));
        head_next    = (vw_cnt_reg != '0) ? vw_mem[vw_rp_reg] : '0;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            err_reg       <= `ESBSR_ERR_RST;
            reg_readdata  <= `ESBSR_RDATA_RST;
            espi_alert_n  <= 1'b1;
            vw_head       <= '0;
            espi_data_out <= '0;
            espi_data_oe  <= '0;
        end else begin
            err_reg       <= err_next;
            reg_readdata  <= rdata_next;
            espi_alert_n  <= alert_n_next;
            vw_head       <= head_next;
            // lanes are never driven here; data out and enable held at zero
            espi_data_out <= '0;
            espi_data_oe  <= '0;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    chk_err_readback: assert property (
        reg_read && reg_address == `ESBSR_ERROR_OFS
        |=> reg_readdata == {24'h00_0000, $past(err_reg)})
        else $error("error register readback mismatch");
    chk_posted_free: assert property (
        fifo_ev.posted_put |=> !status_word[`ESBSR_ST_PFREE]
        && status_word[`ESBSR_ST_PAVAIL])
        else $error("posted free still set after put");
    chk_nonposted_free: assert property (
        reg_read && reg_address == `ESBSR_STATUS_OFS
        |=> reg_readdata[`ESBSR_ST_NPFREE] == !$past(np_occ_reg))
        else $error("nonposted free wrong");
    chk_fixed_bits: assert property (
        reg_read && reg_address == `ESBSR_STATUS_OFS
        |=> reg_readdata[9:8] == 2'h3 && reg_readdata[3:2] == 2'h3
        && reg_readdata[13:12] == 2'h0 && !reg_readdata[5]
        && !reg_readdata[7])
        else $error("fixed status bits wrong");
    chk_posted_avail: assert property (
        reg_read && reg_address == `ESBSR_STATUS_OFS
        |=> reg_readdata[`ESBSR_ST_PAVAIL] != reg_readdata[`ESBSR_ST_PFREE])
        else $error("posted available not opposite of free");
    chk_vw_queue: assert property (
        arst_n && vw_wires != vw_last_reg && !vw_full && !fifo_ev.vw_get
        |=> vw_cnt_reg == $past(vw_cnt_reg) + 1'b1
        && vw_last_reg == $past(vw_wires))
        else $error("wire change not queued");
    chk_link_rst_keep: assert property (
        !lrst_n_reg && !vw_push && !vw_pop && $stable(fifo_ev)
        && fifo_ev == '0 |=> $stable(vw_cnt_reg) && $stable(pc_occ_reg)
        && $stable(np_occ_reg))
        else $error("fifo state lost under link reset");
    chk_lane_mode: assert property (
        (LANES == 2 || LANES == 4) && espi_data_oe == '0)
        else $error("lane mode or lane drive wrong");
    chk_err_clear: assert property (
        reg_write && reg_address == `ESBSR_ERROR_OFS && reg_writedata[0]
        && !err_event[0] |=> !err_reg[0])
        else $error("error bit not cleared by one");
    chk_err_set: assert property (
        err_event[2] |=> err_reg[2] [*2] or (err_reg[2] ##1 1'b1))
        else $error("error event not latched");
    chk_status_ro: assert property (
        reg_read |=> reg_readdata[31:14] == 18'h0_0000
        && reg_readdata[11:10] == 2'h0)
        else $error("reserved bits not zero");

    cov_posted_cycle: cover property (
        fifo_ev.posted_put ##[1:20] fifo_ev.posted_drain);
    cov_vw_full: cover property (vw_full);
    cov_err_clear: cover property (
        err_reg != '0 ##1 reg_write ##1 err_reg == '0);
    cov_alert: cover property (!espi_alert_n);

endmodule : esbsr_status_regs

// >>> testbench/esbsr_host_model.sv
`timescale 1ns/10ps

module esbsr_host_model
    import esbsr_pkg::*;
#(
    parameter int LANES = 4
) (
    output logic                  espi_clk,
    output logic                  espi_reset_n,
    output logic                  espi_cs_n,
    output wire logic [LANES-1:0] espi_data_in,
    input  wire logic [LANES-1:0] espi_data_out,
    input  wire logic [LANES-1:0] espi_data_oe
);
    // ------------------------------------------------------------------
    // serial link host side
    // ------------------------------------------------------------------
    // 33 MHz link clock
    localparam realtime HALF = 15.0;
    logic [LANES-1:0] host_val;

    // same lane count, wire level chosen by the bridge enable alone
    assign espi_data_in = (espi_data_oe & espi_data_out)
                        | (~espi_data_oe & host_val);

    initial begin
        espi_clk     = 1'b0;
        espi_reset_n = 1'b1;
        espi_cs_n    = 1'b1;
        host_val     = '0;
    end

    // clock runs only inside a frame, lines invert once released
    task automatic frame(input int cycles);
        espi_cs_n = 1'b0;
        for (int i = 0; i < cycles; i++) begin
            host_val = LANES'(i + 5);
            #HALF espi_clk = 1'b1;
            #HALF espi_clk = 1'b0;
        end
        espi_cs_n = 1'b1;
        host_val  = ~host_val;
    endtask : frame

    task automatic link_reset(input int cycles);
        espi_reset_n = 1'b0;
        repeat (cycles) #(2 * HALF);
        espi_reset_n = 1'b1;
    endtask : link_reset
endmodule : esbsr_host_model

// >>> testbench/tb_espi_bridge_status_regs.sv
`timescale 1ns/10ps

`define CHK(nm, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("[FAIL] %s exp %h got %h", nm, exp, got); \
        end \
    end

module tb_espi_bridge_status_regs
    import esbsr_pkg::*;
;
    typedef struct packed {
        logic [4:0]  ev;
        logic [4:0]  addr;
        logic [31:0] exp;
    } esbsr_row_t;

    logic            clk;
    logic            arst_n;
    logic            reg_write;
    logic            reg_read;
    logic [4:0]      reg_address;
    logic [31:0]     reg_writedata;
    logic [31:0]     reg_readdata;
    logic            espi_clk;
    logic            espi_reset_n;
    logic            espi_cs_n;
    wire  [3:0]      espi_data_in;
    logic [3:0]      espi_data_out;
    logic [3:0]      espi_data_oe;
    logic            espi_alert_n;
    esbsr_fifo_ev_t  fifo_ev;
    logic [7:0]      vw_wires;
    esbsr_vw_entry_t vw_head;
    logic [7:0]      err_event;
    logic [31:0]     rdv;
    int              n_mismatch;
    int              check_count;

    // ------------------------------------------------------------------
    // ordinary cases: fifo event, then read
    // ------------------------------------------------------------------
    esbsr_row_t rows [7] = '{
        '{5'h00, 5'h00, 32'h0000_030F},
        '{5'h10, 5'h00, 32'h0000_031E},
        '{5'h04, 5'h00, 32'h0000_031C},
        '{5'h08, 5'h00, 32'h0000_030D},
        '{5'h02, 5'h00, 32'h0000_030F},
        '{5'h00, 5'h08, 32'h0000_0000},
        '{5'h00, 5'h04, 32'h0000_0000}
    };

    esbsr_status_regs esbsr_status_regs_i (
        .clk           (clk),
        .arst_n        (arst_n),
        .reg_write     (reg_write),
        .reg_read      (reg_read),
        .reg_address   (reg_address),
        .reg_writedata (reg_writedata),
        .reg_readdata  (reg_readdata),
        .espi_clk      (espi_clk),
        .espi_reset_n  (espi_reset_n),
        .espi_cs_n     (espi_cs_n),
        .espi_data_in  (espi_data_in),
        .espi_data_out (espi_data_out),
        .espi_data_oe  (espi_data_oe),
        .espi_alert_n  (espi_alert_n),
        .fifo_ev       (fifo_ev),
        .vw_wires      (vw_wires),
        .vw_head       (vw_head),
        .err_event     (err_event)
    );

    esbsr_host_model esbsr_host_model_i (
        .espi_clk      (espi_clk),
        .espi_reset_n  (espi_reset_n),
        .espi_cs_n     (espi_cs_n),
        .espi_data_in  (espi_data_in),
        .espi_data_out (espi_data_out),
        .espi_data_oe  (espi_data_oe)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // bus and event tasks, entered at a rising edge
    // ------------------------------------------------------------------
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        reg_read    <= 1'b1;
        reg_address <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_readdata;
        @(posedge clk);
    endtask : rd

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        reg_write     <= 1'b1;
        reg_address   <= a;
        reg_writedata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic pulse_ev(input logic [4:0] ev);
        fifo_ev <= esbsr_fifo_ev_t'(ev);
        @(posedge clk);
        fifo_ev <= '0;
        @(posedge clk);
    endtask : pulse_ev

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    initial begin
        #100000;
        n_mismatch++;
        close_out();
    end

    initial begin
        n_mismatch  = 0;
        check_count = 0;
        arst_n = 1'b0;
        {reg_write, reg_read, reg_address, reg_writedata} = '0;
        fifo_ev   = '0;
        vw_wires  = 8'h00;
        err_event = 8'h00;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("alert idle", 1'b1, espi_alert_n)
        `CHK("data oe", 4'h0, espi_data_oe)
        `CHK("data out", 4'h0, espi_data_out)
        foreach (rows[i]) begin
            pulse_ev(rows[i].ev);
            rd(rows[i].addr, rdv);
            `CHK("row read", rows[i].exp, rdv)
        end
        wr(5'h00, 32'hFFFF_FFFF);
        rd(5'h00, rdv);
        `CHK("status write", 32'h0000_030F, rdv)
        pulse_ev(5'h10);
        pulse_ev(5'h10);
        rd(5'h04, rdv);
        `CHK("put no free", 32'h0000_0010, rdv)
        esbsr_host_model_i.link_reset(20);
        esbsr_host_model_i.frame(16);
        @(posedge clk);
        rd(5'h00, rdv);
        `CHK("link reset keeps", 32'h0000_031E, rdv)
        pulse_ev(5'h08);
        err_event <= 8'hFF;
        @(posedge clk);
        err_event <= 8'h01;
        reg_read      <= 1'b1;
        reg_write     <= 1'b1;
        reg_address   <= 5'h04;
        reg_writedata <= 32'hFFFF_FFFF;
        @(posedge clk);
        {reg_read, reg_write, err_event} <= '0;
        #1 `CHK("err all", 32'h0000_00FF, reg_readdata)
        @(posedge clk);
        rd(5'h04, rdv);
        `CHK("set beats clear", 32'h0000_0001, rdv)
        wr(5'h04, 32'h0000_0001);
        rd(5'h04, rdv);
        `CHK("err cleared", 32'h0000_0000, rdv)
        vw_wires <= 8'h5A;
        repeat (6) @(posedge clk);
        rd(5'h00, rdv);
        `CHK("vw avail", 32'h0000_034F, rdv)
        `CHK("vw head", 16'h005A, vw_head)
        `CHK("alert low", 1'b0, espi_alert_n)
        pulse_ev(5'h01);
        rd(5'h00, rdv);
        `CHK("vw drained", 32'h0000_030F, rdv)
        // ------------------------------------------------------------------
        // bridge reset in mid-run empties the packet fifos and errors; the held wire level queues again
        // ------------------------------------------------------------------
        pulse_ev(5'h10);
        pulse_ev(5'h10);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(5'h00, rdv);
        `CHK("reset empties", 32'h0000_034F, rdv)
        rd(5'h04, rdv);
        `CHK("reset errors", 32'h0000_0000, rdv)
        close_out();
    end
endmodule : tb_espi_bridge_status_regs
